/* File: inc/sbtc_pkg.sv */
package sbtc_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] SBTC_OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] SBTC_OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] SBTC_OFS_PERIPH_FLAG = 8'h08;
  localparam logic [7:0] SBTC_OFS_PERIPH_ENABLE = 8'h0C;
  localparam logic [7:0] SBTC_OFS_COUNTER_CONTROL = 8'h10;
  localparam int SBTC_ADDR_W = 8;

  // ****************************************
  // control fields
  // ****************************************
  localparam int SBTC_CTL_RUN = 0;
  localparam int SBTC_CTL_CLK_SEL = 1;
  localparam int SBTC_CTL_SYNC_BYPASS = 2;
  localparam int SBTC_CTL_OSC_EN = 3;
  localparam int SBTC_CTL_PS_LO = 4;
  localparam int SBTC_CTL_PS_HI = 5;
  localparam logic [7:0] SBTC_CTL_WMASK = 8'h3F;
  localparam logic [7:0] SBTC_CTL_RESET = 8'h00;
  localparam int SBTC_FLAG_OVF = 0;
  localparam int SBTC_IE_OVF = 0;

  // ****************************************
  // count and prescaler
  // ****************************************
  localparam logic [15:0] SBTC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] SBTC_COUNT_ZERO = 16'h0000;
  localparam logic [1:0] SBTC_PS_DIV1 = 2'h0;
  localparam logic [1:0] SBTC_PS_DIV2 = 2'h1;
  localparam logic [1:0] SBTC_PS_DIV4 = 2'h2;
  localparam logic [1:0] SBTC_PS_DIV8 = 2'h3;
  localparam logic [2:0] SBTC_PS_MASK1 = 3'h0;
  localparam logic [2:0] SBTC_PS_MASK2 = 3'h1;
  localparam logic [2:0] SBTC_PS_MASK4 = 3'h3;
  localparam logic [2:0] SBTC_PS_MASK8 = 3'h7;
  localparam logic [1:0] SBTC_PINS_INPUT = 2'h3;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] SBTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBTC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SBTC_SEL_LOW = 3'b000,
    SBTC_SEL_HIGH = 3'b001,
    SBTC_SEL_FLAG = 3'b010,
    SBTC_SEL_IE = 3'b011,
    SBTC_SEL_CTL = 3'b100,
    SBTC_SEL_NONE = 3'b111
  } sbtc_sel_t;
endpackage

/* File: rtl/sbtc_timer.sv */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module sbtc_timer
  import sbtc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep,
  input wire logic osc_input_pin,
  input wire logic ext_clock_pin,
  input wire logic [1:0] port_c_direction,
  input wire logic ccp1_reset,
  input wire logic ccp2_reset,
  output logic overflow_irq,
  output logic wake_request,
  output logic osc_amp_enable,
  output logic [1:0] osc_pins_input,
  output logic timebase_valid
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic sbtc_sel_t sel_of(input logic [SBTC_ADDR_W-1:0] a);
    case (a)
      SBTC_OFS_COUNT_LOW: sel_of = SBTC_SEL_LOW;
      SBTC_OFS_COUNT_HIGH: sel_of = SBTC_SEL_HIGH;
      SBTC_OFS_PERIPH_FLAG: sel_of = SBTC_SEL_FLAG;
      SBTC_OFS_PERIPH_ENABLE: sel_of = SBTC_SEL_IE;
      SBTC_OFS_COUNTER_CONTROL: sel_of = SBTC_SEL_CTL;
      default: sel_of = SBTC_SEL_NONE;
    endcase
  endfunction

  logic [7:0] aw_addr_reg, w_data_reg, control_reg;
  logic aw_held_reg, w_lane_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg, pins_in_reg, ps_sel;
  logic [31:0] rdata_reg;
  logic wr_fire, wr_low, wr_high, count_wr;
  sbtc_sel_t wr_sel, rd_sel;
  logic ovf_flag_reg, ovf_ie_reg, ext_prev_reg, sync_prev_reg;
  logic [15:0] count_reg, count_next;
  logic [2:0] pre_cnt_reg, ps_mask;
  logic [SYNC_STAGES-1:0] sync_reg;
  logic irq_reg, wake_reg, osc_amp_reg, timebase_reg;
  logic run, clk_sel, bypass, osc_en, ext_pin, ext_rise, src_tick;
  logic pre_full, pre_level, direct_tick, sync_tick, advance, ccp_reset, wrap;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_sel = sel_of(aw_addr_reg);
  assign rd_sel = sel_of(s_axi_araddr);
  assign wr_low = wr_fire && w_lane_reg && (wr_sel == SBTC_SEL_LOW);
  assign wr_high = wr_fire && w_lane_reg && (wr_sel == SBTC_SEL_HIGH);
  assign count_wr = wr_low || wr_high;

  // address and data are taken in either order, one write at a time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= SBTC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == SBTC_SEL_NONE) ? SBTC_RESP_SLVERR : SBTC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // count is kept in the bus clock domain, so both bytes always read whole
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= SBTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= SBTC_RESP_OKAY;
      case (rd_sel)
        SBTC_SEL_LOW: rdata_reg <= {24'h000000, count_reg[7:0]};
        SBTC_SEL_HIGH: rdata_reg <= {24'h000000, count_reg[15:8]};
        SBTC_SEL_FLAG: rdata_reg <= {31'h00000000, ovf_flag_reg};
        SBTC_SEL_IE: rdata_reg <= {31'h00000000, ovf_ie_reg};
        SBTC_SEL_CTL: rdata_reg <= {24'h000000, control_reg & SBTC_CTL_WMASK};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= SBTC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ****************************************
  // software registers
  // ****************************************
  // rst stands for power-on and brown-out only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_reg <= SBTC_CTL_RESET;
    end else if (wr_fire && w_lane_reg && wr_sel == SBTC_SEL_CTL) begin
      control_reg <= w_data_reg & SBTC_CTL_WMASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_ie_reg <= 1'b0;
    end else if (wr_fire && w_lane_reg && wr_sel == SBTC_SEL_IE) begin
      ovf_ie_reg <= w_data_reg[SBTC_IE_OVF];
    end
  end

  // a wrap in the same cycle as a software clear keeps the flag set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_flag_reg <= 1'b0;
    end else if (wrap) begin
      ovf_flag_reg <= 1'b1;
    end else if (wr_fire && w_lane_reg && wr_sel == SBTC_SEL_FLAG) begin
      ovf_flag_reg <= w_data_reg[SBTC_FLAG_OVF];
    end
  end

  assign run = control_reg[SBTC_CTL_RUN];
  assign clk_sel = control_reg[SBTC_CTL_CLK_SEL];
  assign bypass = control_reg[SBTC_CTL_SYNC_BYPASS];
  assign osc_en = control_reg[SBTC_CTL_OSC_EN];
  assign ps_sel = control_reg[SBTC_CTL_PS_HI:SBTC_CTL_PS_LO];

  // ****************************************
  // clock source and prescaler
  // ****************************************
  assign ext_pin = osc_en ? osc_input_pin : ext_clock_pin;
  assign ext_rise = ext_pin && !ext_prev_reg;
  // the instruction clock stops in sleep; external edges keep coming
  assign src_tick = clk_sel ? ext_rise : !sleep;

  always_comb begin
    case (ps_sel)
      SBTC_PS_DIV1: ps_mask = SBTC_PS_MASK1;
      SBTC_PS_DIV2: ps_mask = SBTC_PS_MASK2;
      SBTC_PS_DIV4: ps_mask = SBTC_PS_MASK4;
      SBTC_PS_DIV8: ps_mask = SBTC_PS_MASK8;
      default: ps_mask = SBTC_PS_MASK1;
    endcase
  end

  assign pre_full = (pre_cnt_reg & ps_mask) == ps_mask;
  assign direct_tick = src_tick && pre_full;

  // prescaler output level, which the synchroniser samples
  always_comb begin
    case (ps_sel)
      SBTC_PS_DIV1: pre_level = ext_pin;
      SBTC_PS_DIV2: pre_level = pre_cnt_reg[0];
      SBTC_PS_DIV4: pre_level = pre_cnt_reg[1];
      SBTC_PS_DIV8: pre_level = pre_cnt_reg[2];
      default: pre_level = ext_pin;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_pin;
    end
  end

  // prescaler keeps counting external edges in sleep (the internal source stops), it is not gated by the synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 3'h0;
    end else if (count_wr) begin
      pre_cnt_reg <= 3'h0;
    end else if (src_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
    end
  end

  // ****************************************
  // synchroniser
  // ****************************************
  // shut off in sleep: stages hold, so no edge can be seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
      sync_prev_reg <= 1'b0;
    end else if (!sleep) begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], pre_level};
      sync_prev_reg <= sync_reg[SYNC_STAGES-1];
    end
  end

  assign sync_tick = sync_reg[SYNC_STAGES-1] && !sync_prev_reg && !sleep;

  // internal source ignores the sync bit; unsynced path runs even in sleep
  always_comb begin
    if (!run) begin
      advance = 1'b0;
    end else if (!clk_sel) begin
      advance = direct_tick;
    end else if (bypass) begin
      advance = direct_tick;
    end else begin
      advance = sync_tick;
    end
  end

  // ****************************************
  // count
  // ****************************************
  assign ccp_reset = ccp1_reset || ccp2_reset;
  assign wrap = advance && !ccp_reset && !count_wr && (count_reg == SBTC_COUNT_MAX);

  always_comb begin
    count_next = count_reg;
    // a count write suppresses the whole reset, so the other byte is not cleared; it still steps if advance is set
    if (ccp_reset && !count_wr) begin
      count_next = SBTC_COUNT_ZERO;
    end else if (advance) begin
      count_next = count_reg + 16'h0001;
    end
    // software write last so that it beats the capture-compare reset
    if (wr_low) begin
      count_next[7:0] = w_data_reg;
    end
    if (wr_high) begin
      count_next[15:8] = w_data_reg;
    end
  end

  // no reset on purpose: count survives every device reset
  always_ff @(posedge sys_clk) begin
    count_reg <= count_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= ovf_flag_reg && ovf_ie_reg;
      wake_reg <= ovf_flag_reg && ovf_ie_reg && sleep && clk_sel && bypass;
    end
  end

  // oscillator is not stopped by sleep, only by its enable bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_amp_reg <= 1'b0;
      pins_in_reg <= SBTC_PINS_INPUT;
      timebase_reg <= 1'b1;
    end else begin
      osc_amp_reg <= osc_en;
      pins_in_reg <= osc_en ? SBTC_PINS_INPUT : port_c_direction;
      timebase_reg <= !(clk_sel && bypass);
    end
  end

  assign overflow_irq = irq_reg;
  assign wake_request = wake_reg;
  assign osc_amp_enable = osc_amp_reg;
  assign osc_pins_input = pins_in_reg;
  assign timebase_valid = timebase_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  wrap_sets_flag_a: assert property (wrap |=> ovf_flag_reg)
    else $error("wrap did not set overflow flag");
  irq_gate_a: assert property (overflow_irq |-> $past(ovf_flag_reg && ovf_ie_reg))
    else $error("interrupt without flag and enable");
  count_step_a: assert property (advance && !ccp_reset && !count_wr
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step by one");
  stopped_hold_a: assert property (!run && !ccp_reset && !count_wr |=> $stable(count_reg))
    else $error("count moved while stopped");
  ccp_clear_a: assert property (ccp_reset && !count_wr |=> count_reg == SBTC_COUNT_ZERO)
    else $error("capture-compare reset did not clear");
  write_wins_a: assert property (wr_low && ccp_reset
    |=> count_reg[7:0] == $past(w_data_reg))
    else $error("write lost to capture-compare reset");
  pre_clear_a: assert property (count_wr |=> pre_cnt_reg == 3'h0)
    else $error("prescaler not cleared by count write");
  sleep_sync_a: assert property (sleep && clk_sel && !bypass |-> !advance)
    else $error("synchronised counter advanced in sleep");
  pins_forced_a: assert property (osc_en |=> osc_pins_input == SBTC_PINS_INPUT)
    else $error("oscillator pins not forced to input");
  ctl_top_zero_a: assert property (control_reg[7:6] == 2'h0)
    else $error("unimplemented control bits set");
  div8_a: assert property (run && !clk_sel && ps_sel == SBTC_PS_DIV8 && !sleep && advance
    && !count_wr |=> !advance ##1 !advance)
    else $error("divide by eight ticked too often");

  wrap_seen_c: cover property (wrap);
  async_sleep_c: cover property (sleep && clk_sel && bypass && advance);
  write_vs_ccp_c: cover property (count_wr && ccp_reset);
  sync_edge_c: cover property (clk_sel && !bypass && sync_tick);

endmodule

/* File: tb/sbtc_clk_src.sv */
`timescale 1ns/1ps
// ****************************************
// external clock source model
// ****************************************
module sbtc_clk_src (
  input wire logic sys_clk,
  output logic osc_input_pin,
  output logic ext_clock_pin
);
  // pins stand still low between bursts, as a stopped source would
  initial begin
    osc_input_pin = 1'b0;
    ext_clock_pin = 1'b0;
  end

  // offset of 7 ns keeps every pin change clear of a sampling edge
  task automatic burst(input int n_osc, input int n_ext, input int half);
    @(posedge sys_clk);
    #7;
    fork
      repeat (n_osc) begin
        osc_input_pin = 1'b1;
        #(half);
        osc_input_pin = 1'b0;
        #(half);
      end
      repeat (n_ext) begin
        ext_clock_pin = 1'b1;
        #(half);
        ext_clock_pin = 1'b0;
        #(half);
      end
    join
  endtask
endmodule

/* File: tb/sixteen_bit_timer_counter_test.sv */
`timescale 1ns/1ps
module sixteen_bit_timer_counter_test;
  import sbtc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr, c;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, port_dir, pins_in, resp, ps;
  logic sleep, osc_pin, ext_pin, ccp1, ccp2, irq, wake, amp, tb_valid, osc, byp;
  logic [31:0] lfsr = 32'h6A2FC52B;
  logic [15:0] cnt, s;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, half;

  always #20 sys_clk = ~sys_clk;

  sbtc_timer #(.SYNC_STAGES(2)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep(sleep), .osc_input_pin(osc_pin), .ext_clock_pin(ext_pin),
    .port_c_direction(port_dir), .ccp1_reset(ccp1), .ccp2_reset(ccp2),
    .overflow_irq(irq), .wake_request(wake), .osc_amp_enable(amp),
    .osc_pins_input(pins_in), .timebase_valid(tb_valid));

  sbtc_clk_src u_src (.sys_clk(sys_clk), .osc_input_pin(osc_pin), .ext_clock_pin(ext_pin));

  // ****************************************
  // reporting
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the run should need well under 20000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 50000) begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rnd16();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction

  // prescaler cleared by the count write: direct path steps on the last edge
  // of each group, synchronised path on the rise of the prescaler bit
  function automatic logic [15:0] exp_cnt(logic [15:0] st, int k, logic [1:0] p, bit sy);
    return st + 16'((sy ? k + ((1 << p) >> 1) : k) >> p);
  endfunction

  // hit raises a capture-compare reset on the very edge of the register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit hit = 1'b0);
    bit aw_ok, w_ok, fired;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    fired = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (hit) begin
        ccp1 <= aw_ok && w_ok && !fired;
        fired = aw_ok && w_ok;
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(SBTC_OFS_COUNT_LOW, v[7:0]);
    wr(SBTC_OFS_COUNT_HIGH, v[15:8]);
  endtask

  task automatic getcnt();
    rd(SBTC_OFS_COUNT_LOW, rv);
    cnt[7:0] = rv[7:0];
    rd(SBTC_OFS_COUNT_HIGH, rv);
    cnt[15:8] = rv[7:0];
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    sleep = 1'b0;
    // count has no reset; a clear during reset gives it a known start
    ccp1 = 1'b1;
    ccp2 = 1'b0;
    port_dir = 2'h1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    ccp1 <= 1'b0;
    rd(SBTC_OFS_COUNTER_CONTROL, rv);
    chk(rv, 32'h0);
    chk(pins_in, 2'h1);
    chk(amp, 1'b0);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'hFF);
    rd(SBTC_OFS_COUNTER_CONTROL, rv);
    chk(rv, 32'h3F);
    chk(amp, 1'b1);
    chk(pins_in, SBTC_PINS_INPUT);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h00);
    rd(8'h14, rv);
    chk(resp, SBTC_RESP_SLVERR);
    chk(rv, 32'h0);
    wr(8'h18, 8'h5A);
    chk(resp, SBTC_RESP_SLVERR);
    // every prescale, both pins, synchronised and not
    for (int i = 0; i < 16; i++) begin
      ps = 2'(i);
      osc = i[2];
      byp = i[3];
      half = (i % 2) ? 200 : 120;
      c = {2'b00, ps, osc, byp, 1'b1, 1'b0};
      wr(SBTC_OFS_COUNTER_CONTROL, c); // stopped before the count write
      s = rnd16();
      n = int'(rnd16() % 16'd24) + 1;
      setcnt(s);
      wr(SBTC_OFS_COUNTER_CONTROL, c | 8'h01);
      u_src.burst(osc ? n : n + 5, osc ? n + 5 : n, half);
      repeat (8) @(posedge sys_clk);
      chk(tb_valid, !byp);
      wr(SBTC_OFS_COUNTER_CONTROL, c);
      getcnt();
      chk(cnt, exp_cnt(s, n, ps, !byp));
      u_src.burst(3, 3, 120);
      repeat (8) @(posedge sys_clk);
      getcnt();
      chk(cnt, exp_cnt(s, n, ps, !byp));
    end
    // internal clock: 64 run edges between the run and the stop write,
    // the stop write selects the external source so nothing ticks while stopped
    for (int p = 0; p < 4; p++) begin
      setcnt(16'h0000);
      wr(SBTC_OFS_COUNTER_CONTROL, {2'b00, 2'(p), 1'b0, p[0], 2'b01});
      repeat (60) @(posedge sys_clk);
      wr(SBTC_OFS_COUNTER_CONTROL, 8'h02);
      getcnt();
      chk(cnt, 16'(16'h0040 >> p));
    end
    // synchronised mode halts in sleep
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h02);
    setcnt(16'h1234);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h03);
    @(posedge sys_clk);
    sleep <= 1'b1;
    u_src.burst(0, 5, 120);
    repeat (8) @(posedge sys_clk);
    sleep <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h02);
    getcnt();
    chk(cnt, 16'h1234);
    // unsynchronised wrap in sleep wakes the processor
    wr(SBTC_OFS_PERIPH_FLAG, 8'h00);
    wr(SBTC_OFS_PERIPH_ENABLE, 8'h01);
    setcnt(16'hFFFE);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h07);
    @(posedge sys_clk);
    sleep <= 1'b1;
    u_src.burst(0, 2, 200);
    repeat (4) @(posedge sys_clk);
    chk(wake, 1'b1);
    chk(irq, 1'b1);
    sleep <= 1'b0;
    rd(SBTC_OFS_PERIPH_FLAG, rv);
    chk(rv, 32'h1);
    wr(SBTC_OFS_PERIPH_ENABLE, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    wr(SBTC_OFS_COUNTER_CONTROL, 8'h02);
    getcnt();
    chk(cnt, 16'h0000);
    wr(SBTC_OFS_PERIPH_FLAG, 8'h00);
    // capture-compare resets from both units
    for (int k = 0; k < 2; k++) begin
      setcnt(rnd16() | 16'h0100);
      @(posedge sys_clk);
      ccp1 <= (k == 0);
      ccp2 <= (k == 1);
      @(posedge sys_clk);
      ccp1 <= 1'b0;
      ccp2 <= 1'b0;
      getcnt();
      chk(cnt, 16'h0000);
      rd(SBTC_OFS_PERIPH_FLAG, rv);
      chk(rv, 32'h0);
    end
    s = rnd16();
    wr(SBTC_OFS_COUNT_HIGH, s[15:8]);
    wr(SBTC_OFS_COUNT_LOW, s[7:0], 1'b1);
    getcnt();
    chk(cnt, s);
    // a device reset leaves the count alone
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    getcnt();
    chk(cnt, s);
    rd(SBTC_OFS_COUNTER_CONTROL, rv);
    chk(rv, 32'h0);
    summarize();
  end
endmodule
